// *** dv/adc_link_sva.sv ***
`timescale 1ns/1ps
module adc_link_sva (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic conversion_start,
  input wire logic burst_clk,
  input wire logic serial_data,
  input wire logic echo_clock_out,
  input wire logic ref_mode_sel_hi,
  input wire logic ref_mode_sel_lo,
  input wire logic self_clock_tie
);
  logic [7:0] since_r, since_nxt;
  logic [4:0] rises_r, rises_nxt;
  logic mode_r, mode_nxt, seen_r, seen_nxt, start_q_r, bclk_q_r, data_q_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // ************************************************
  // Conversion tracking
  // ************************************************
  // Rises counted only inside the burst window, so an idle-level swap on a mode change is ignored
  always_comb begin
    since_nxt = (since_r == 8'hFF) ? since_r : since_r + 8'h01;
    rises_nxt = rises_r;
    mode_nxt = mode_r;
    seen_nxt = seen_r;
    // Window ends before the host can swap idle levels after a finished read
    if (burst_clk && !bclk_q_r && since_r < 8'h82) begin
      rises_nxt = rises_r + 5'h01;
    end
    if (conversion_start && !start_q_r) begin
      since_nxt = 8'h00;
      rises_nxt = 5'h00;
      mode_nxt = self_clock_tie;
      seen_nxt = 1'b1;
    end
  end

  // State registers of the tracker
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      since_r <= 8'hFF;
      rises_r <= 5'h00;
      mode_r <= 1'b0;
      seen_r <= 1'b0;
      start_q_r <= 1'b0;
      bclk_q_r <= 1'b0;
      data_q_r <= 1'b0;
    end else begin
      since_r <= since_nxt;
      rises_r <= rises_nxt;
      mode_r <= mode_nxt;
      seen_r <= seen_nxt;
      start_q_r <= conversion_start;
      bclk_q_r <= burst_clk;
      data_q_r <= serial_data;
    end
  end

  // ************************************************
  // Link assertions
  // ************************************************
  start_width_a: assert property ($rose(conversion_start) |-> conversion_start[*5] ##1 !conversion_start)
    else $error("start pulse width wrong");
  burst_gate_a: assert property (since_r < 8'h14 |-> burst_clk == mode_r)
    else $error("burst began before msb ready");
  pulse_count_a: assert property (seen_r && $rose(conversion_start) |-> rises_r == (mode_r ? 5'h12 : 5'h10))
    else $error("burst pulse count wrong");
  echo_idle_a: assert property (!mode_r && since_r < 8'h82 && $rose(burst_clk) |-> burst_clk[*3] ##1 !burst_clk)
    else $error("echo burst shape wrong");
  self_idle_a: assert property (mode_r && since_r < 8'h82 && $fell(burst_clk) |-> !burst_clk[*3] ##1 burst_clk)
    else $error("self burst shape wrong");
  echo_follow_a: assert property (!mode_r && since_r < 8'h82 && $rose(burst_clk) |-> ##[1:8] $rose(echo_clock_out))
    else $error("echo clock missing");
  // Data must not move at the echo rise nor one cycle after it; it moves near the echo fall
  echo_setup_a: assert property (!mode_r && $rose(echo_clock_out)
    |-> serial_data == data_q_r ##1 serial_data == data_q_r)
    else $error("data moved near echo rise");
  blank_zero_a: assert property (!self_clock_tie && $rose(conversion_start)
    |-> ##14 (!serial_data && !echo_clock_out)[*6])
    else $error("blanking not zero");
  self_echo_zero_a: assert property (mode_r && since_r < 8'h82 |-> !echo_clock_out)
    else $error("echo active in self mode");
  header_seq_a: assert property (mode_r && since_r == 8'h17 |-> !serial_data ##[1:8] serial_data)
    else $error("self header wrong");

  // Main scenarios reached
  cover property ($rose(conversion_start) && self_clock_tie);
  cover property ($rose(conversion_start) && !self_clock_tie);
  cover property ($rose(echo_clock_out));
endmodule

// *** dv/adc_lvds_serial_readout_tb.sv ***
`timescale 1ns/1ps
`include "adc_link_defs.svh"
module adc_lvds_serial_readout_tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic start_in = 1'b0;
  logic [1:0] ref_mode_in = 2'h0;
  logic self_mode_in = 1'b0;
  logic [15:0] sample_in = 16'h0000;
  logic [15:0] sample2 = 16'h0000;
  logic [15:0] h_res, d_res, d2_res;
  logic h_val, h_err, h_busy, h_set, d_val, d_stb, d_pd, d2_val, d2_stb, d2_pd;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int last_start = 0;
  int n_stb2 = 0;
  bit first = 1'b1;
  logic [1:0] modes [3] = '{2'h3, 2'h1, 2'h2};
  int wk [3] = '{50, 20, `WAKE_EXTREF_CYC};
  logic [15:0] corner [6] = '{16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF, 16'h8001, 16'h0001};

  adc_link_if link ();
  adc_link_if link2 ();

  // ************************************************
  // Both ends face each other; a spare converter end is driven by hand
  // ************************************************
  adc_host_end #(.WAKE_INT_CYC(50), .WAKE_EXT12_CYC(20)) adc_host_end_inst (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .link(link), .start_in(start_in), .ref_mode_in(ref_mode_in),
    .self_mode_in(self_mode_in), .result_out(h_res), .result_valid_out(h_val), .header_err_out(h_err),
    .busy_out(h_busy), .settled_out(h_set));
  adc_device_end adc_device_end_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link),
    .sample_in(sample_in), .result_out(d_res), .result_valid_out(d_val), .result_strobe_out(d_stb),
    .powered_down_out(d_pd));
  adc_device_end adc_device_end_inst_b (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link2),
    .sample_in(sample2), .result_out(d2_res), .result_valid_out(d2_val), .result_strobe_out(d2_stb),
    .powered_down_out(d2_pd));
  adc_link_sva adc_link_sva_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .conversion_start(link.conversion_start), .burst_clk(link.burst_clk), .serial_data(link.serial_data),
    .echo_clock_out(link.echo_clock_out), .ref_mode_sel_hi(link.ref_mode_sel_hi),
    .ref_mode_sel_lo(link.ref_mode_sel_lo), .self_clock_tie(link.self_clock_tie));

  // Clock, cycle count and strobe count of the spare end
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (d2_stb === 1'b1) begin
      n_stb2 <= n_stb2 + 1;
    end
  end

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One full conversion through both ends; gaps over 500 cycles lose validity
  task automatic conv(input logic [15:0] s);
    int n;
    bit got;
    bit expv;
    logic [15:0] hr;
    got = 1'b0;
    hr = 16'h0000;
    expv = !first && (cyc - last_start <= 500);
    first = 1'b0;
    last_start = cyc;
    sample_in <= s;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    n = 0;
    while (link.conversion_start !== 1'b1 && n < 10) begin
      @(posedge clk_in);
      n++;
    end
    n = 0;
    while (d_stb !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    chk(n, 23);
    chk(d_res, s);
    chk(d_val, expv);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
      if (h_val === 1'b1) begin
        got = 1'b1;
        hr = h_res;
      end
    end while (h_busy === 1'b1 && n < 400);
    chk(got, 1);
    chk(hr, s);
    chk(h_err, 0);
  endtask

  // Start pulse of fixed width on the spare end
  task automatic pulse2();
    link2.conversion_start <= 1'b1;
    repeat (5) @(posedge clk_in);
    link2.conversion_start <= 1'b0;
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    logic [15:0] a;
    int k;
    link2.conversion_start = 1'b0;
    link2.burst_clk = 1'b0;
    link2.ref_mode_sel_hi = 1'b0;
    link2.ref_mode_sel_lo = 1'b0;
    link2.self_clock_tie = 1'b0;
    void'($urandom(32'hA537));
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    // Wake from power-down into every reference mode
    for (int i = 0; i < 3; i++) begin
      ref_mode_in <= 2'h0;
      repeat (10) @(posedge clk_in);
      chk(d_pd, 1);
      ref_mode_in <= modes[i];
      repeat (wk[i] - 5) @(posedge clk_in);
      chk(h_set, 0);
      repeat (10) @(posedge clk_in);
      chk(h_set, 1);
      chk(d_pd, 0);
    end
    // Boundary codes in both read modes
    for (int i = 0; i < 12; i++) begin
      self_mode_in <= i[0];
      repeat (3) @(posedge clk_in);
      conv(corner[i >> 1]);
    end
    // Random words and modes, some gaps long enough to spoil validity
    for (int i = 0; i < 24; i++) begin
      self_mode_in <= 1'($urandom_range(1, 0));
      repeat (3) @(posedge clk_in);
      if ($urandom_range(4, 0) == 0) begin
        repeat (600) @(posedge clk_in);
      end
      conv(16'($urandom));
    end
    // Spacing exactly at and one cycle past the longest valid period
    for (int i = 500; i < 502; i++) begin
      while (cyc - last_start < i) begin
        @(posedge clk_in);
      end
      conv(16'($urandom));
    end
    // Spare end: a second start inside a conversion must change nothing
    link2.ref_mode_sel_hi <= 1'b1;
    link2.ref_mode_sel_lo <= 1'b1;
    repeat (6) @(posedge clk_in);
    a = 16'($urandom);
    sample2 <= a;
    k = n_stb2;
    pulse2();
    sample2 <= ~a;
    repeat (3) @(posedge clk_in);
    pulse2();
    repeat (60) @(posedge clk_in);
    chk(n_stb2 - k, 1);
    chk(d2_res, a);
    chk(d2_val, 0);
    // Spare end in power-down ignores starts
    link2.ref_mode_sel_hi <= 1'b0;
    link2.ref_mode_sel_lo <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk(d2_pd, 1);
    k = n_stb2;
    pulse2();
    repeat (40) @(posedge clk_in);
    chk(n_stb2 - k, 0);
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_in);
    err_total++;
    final_report();
  end
endmodule

// *** rtl/adc_device_end.sv ***
`timescale 1ns/1ps
`include "adc_link_defs.svh"
module adc_device_end (
  input wire logic clk_in,
  input wire logic arst_n_in,
  adc_link_if.device link,
  input wire logic [15:0] sample_in,
  output logic [15:0] result_out,
  output logic result_valid_out,
  output logic result_strobe_out,
  output logic powered_down_out
);
  logic cnv_rise;
  logic bclk_lvl;
  logic bclk_fall;
  logic sel_hi;
  logic sel_lo;
  logic tie;
  logic pd_req;
  logic blank;
  logic load;
  adc_link_pkg::dev_state_t st_r, st_nxt;
  logic [4:0] tmr_r, tmr_nxt;
  logic [9:0] gap_r, gap_nxt;
  logic first_r, first_nxt;
  logic ok_r, ok_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [18:0] sr_r, sr_nxt;
  logic [15:0] res_nxt;
  logic val_nxt, stb_nxt, pd_nxt, sd_r, sd_nxt, eck_r, eck_nxt;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  edge_sync u_cnv (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.conversion_start),
    .level_out(), .rise_out(cnv_rise), .fall_out());
  edge_sync u_bclk (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.burst_clk),
    .level_out(bclk_lvl), .rise_out(), .fall_out(bclk_fall));
  edge_sync u_hi (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.ref_mode_sel_hi),
    .level_out(sel_hi), .rise_out(), .fall_out());
  edge_sync u_lo (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.ref_mode_sel_lo),
    .level_out(sel_lo), .rise_out(), .fall_out());
  edge_sync u_tie (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.self_clock_tie),
    .level_out(tie), .rise_out(), .fall_out());

  assign pd_req = ~sel_hi & ~sel_lo;
  // Past the deadline the old word is gone and the pins rest low
  assign blank = (st_r == adc_link_pkg::D_CONV) && (tmr_r >= 5'(`LAST_CLOCK_CYC));

  // ************************************************
  // Conversion control
  // ************************************************
  // Gap counter saturates so a long pause still marks the next result stale
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    first_nxt = first_r;
    hold_nxt = hold_r;
    ok_nxt = ok_r;
    load = 1'b0;
    gap_nxt = (gap_r == 10'h3FF) ? gap_r : gap_r + 10'h001;
    case (st_r)
      adc_link_pkg::D_PD: begin
        first_nxt = 1'b1;
        gap_nxt = 10'h000;
        if (!pd_req) begin
          st_nxt = adc_link_pkg::D_IDLE;
        end
      end
      adc_link_pkg::D_IDLE: begin
        if (pd_req) begin
          st_nxt = adc_link_pkg::D_PD;
        end else if (cnv_rise) begin
          st_nxt = adc_link_pkg::D_CONV;
          tmr_nxt = 5'h00;
          hold_nxt = sample_in;
          // Gap holds the spacing minus one, so a spacing of exactly the maximum still counts
          ok_nxt = ~first_r && (gap_r < 10'(`CONV_PERIOD_MAX_CYC));
          first_nxt = 1'b0;
          gap_nxt = 10'h000;
        end
      end
      adc_link_pkg::D_CONV: begin
        // Further start edges are not looked at here
        tmr_nxt = tmr_r + 5'h01;
        if (pd_req) begin
          st_nxt = adc_link_pkg::D_PD;
        end else if (tmr_r == 5'(`MSB_READY_CYC - 1)) begin
          st_nxt = adc_link_pkg::D_IDLE;
          load = 1'b1;
        end
      end
      default: begin
        st_nxt = adc_link_pkg::D_PD;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= adc_link_pkg::D_PD;
      tmr_r <= 5'h00;
      gap_r <= 10'h000;
      first_r <= 1'b1;
      ok_r <= 1'b0;
      hold_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      gap_r <= gap_nxt;
      first_r <= first_nxt;
      ok_r <= ok_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ************************************************
  // Serial output and echo clock
  // ************************************************
  // One shifter serves both modes; the self-clocked word carries its header on top
  always_comb begin
    res_nxt = result_out;
    val_nxt = result_valid_out;
    stb_nxt = load;
    sr_nxt = sr_r;
    if (st_r == adc_link_pkg::D_PD) begin
      sr_nxt = 19'h00000;
    end else if (load) begin
      res_nxt = hold_r;
      val_nxt = ok_r;
      if (tie) begin
        sr_nxt = {`SELF_HEADER, hold_r};
      end else begin
        sr_nxt = {hold_r, 3'h0};
      end
    end else if (bclk_fall && !blank) begin
      sr_nxt = {sr_r[17:0], 1'b0};
    end
    sd_nxt = ~blank & (st_r != adc_link_pkg::D_PD) & sr_r[18];
    eck_nxt = ~tie & ~blank & (st_r != adc_link_pkg::D_PD) & bclk_lvl;
    pd_nxt = (st_nxt == adc_link_pkg::D_PD);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sr_r <= 19'h00000;
      sd_r <= 1'b0;
      eck_r <= 1'b0;
      result_out <= 16'h0000;
      result_valid_out <= 1'b0;
      result_strobe_out <= 1'b0;
      powered_down_out <= 1'b1;
    end else begin
      sr_r <= sr_nxt;
      sd_r <= sd_nxt;
      eck_r <= eck_nxt;
      result_out <= res_nxt;
      result_valid_out <= val_nxt;
      result_strobe_out <= stb_nxt;
      powered_down_out <= pd_nxt;
    end
  end

  assign link.serial_data = sd_r;
  assign link.echo_clock_out = eck_r;
endmodule

// *** rtl/adc_host_end.sv ***
`timescale 1ns/1ps
`include "adc_link_defs.svh"
module adc_host_end #(
  parameter int WAKE_INT_CYC = `WAKE_INT_US * `CLK_PER_US,
  parameter int WAKE_EXT12_CYC = `WAKE_EXT12_US * `CLK_PER_US
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  adc_link_if.host link,
  input wire logic start_in,
  input wire logic [1:0] ref_mode_in,
  input wire logic self_mode_in,
  output logic [15:0] result_out,
  output logic result_valid_out,
  output logic header_err_out,
  output logic busy_out,
  output logic settled_out
);
  logic sdata_s;
  logic echo_rise;
  logic done;
  logic smp_en;
  logic clr;
  adc_link_pkg::host_state_t st_r, st_nxt;
  logic [5:0] tmr_r, tmr_nxt;
  logic [2:0] ph_r, ph_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic cnv_r, cnv_nxt;
  logic bclk_r, bclk_nxt;
  logic self_r, self_nxt;
  logic busy_nxt;
  logic [1:0] ref_r;
  logic [26:0] wake_r, wake_nxt;
  logic settled_nxt;
  logic [15:0] esr_r, esr_nxt;
  logic [2:0] ok;
  logic [15:0] word [3];
  logic [15:0] res_nxt;
  logic val_nxt, err_nxt;

  // ************************************************
  // Return pin synchronisers
  // ************************************************
  edge_sync u_sd (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.serial_data),
    .level_out(sdata_s), .rise_out(), .fall_out());
  edge_sync u_eck (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(link.echo_clock_out),
    .level_out(), .rise_out(echo_rise), .fall_out());

  // ************************************************
  // Reference mode and wake-up tracking
  // ************************************************
  // Any change into a powered mode restarts the settle wait; starts are still allowed meanwhile
  always_comb begin
    wake_nxt = (wake_r == 27'h0000000) ? wake_r : wake_r - 27'h0000001;
    if (ref_mode_in != ref_r) begin
      case (ref_mode_in)
        `REF_INTERNAL: wake_nxt = 27'(WAKE_INT_CYC);
        `REF_EXT12: wake_nxt = 27'(WAKE_EXT12_CYC);
        `REF_EXTFULL: wake_nxt = 27'(`WAKE_EXTREF_CYC);
        default: wake_nxt = 27'h0000000;
      endcase
    end
    settled_nxt = (ref_mode_in != `REF_POWER_DOWN) && (wake_nxt == 27'h0000000);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ref_r <= `REF_POWER_DOWN;
      wake_r <= 27'h0000000;
      settled_out <= 1'b0;
    end else begin
      ref_r <= ref_mode_in;
      wake_r <= wake_nxt;
      settled_out <= settled_nxt;
    end
  end

  // ************************************************
  // Start pulse and burst sequencer
  // ************************************************
  // The burst waits past the ready time plus a margin for the converter's own input sync
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    ph_nxt = ph_r;
    cnt_nxt = cnt_r;
    cnv_nxt = 1'b0;
    self_nxt = self_r;
    bclk_nxt = self_r;
    busy_nxt = 1'b1;
    done = 1'b0;
    case (st_r)
      adc_link_pkg::H_IDLE: begin
        busy_nxt = 1'b0;
        self_nxt = self_mode_in;
        bclk_nxt = self_mode_in;
        if (start_in) begin
          st_nxt = adc_link_pkg::H_WAIT;
          cnv_nxt = 1'b1;
          tmr_nxt = 6'h00;
          busy_nxt = 1'b1;
        end
      end
      adc_link_pkg::H_WAIT: begin
        tmr_nxt = tmr_r + 6'h01;
        cnv_nxt = (tmr_r < 6'(`START_HIGH_CYC - 1));
        if (tmr_r == 6'(`MSB_READY_CYC + `HOST_MARGIN_CYC - 1)) begin
          st_nxt = adc_link_pkg::H_BURST;
          ph_nxt = 3'h0;
          cnt_nxt = 5'h00;
          bclk_nxt = ~self_r;
        end
      end
      adc_link_pkg::H_BURST: begin
        ph_nxt = (ph_r == 3'(`BURST_PERIOD_CYC - 1)) ? 3'h0 : ph_r + 3'h1;
        bclk_nxt = (ph_nxt < 3'(`BURST_HALF_CYC)) ^ self_r;
        if (ph_r == 3'(`BURST_PERIOD_CYC - 1)) begin
          cnt_nxt = cnt_r + 5'h01;
          // Exact pulse count per mode, then back to the idle level
          if (cnt_r == (self_r ? 5'(`SELF_PULSES - 1) : 5'(`ECHO_PULSES - 1))) begin
            st_nxt = adc_link_pkg::H_TAIL;
            cnt_nxt = 5'h00;
            bclk_nxt = self_r;
          end
        end
      end
      adc_link_pkg::H_TAIL: begin
        ph_nxt = (ph_r == 3'(`BURST_PERIOD_CYC - 1)) ? 3'h0 : ph_r + 3'h1;
        if (ph_r == 3'(`BURST_PERIOD_CYC - 1)) begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == 5'(`TAIL_PERIODS - 1)) begin
            st_nxt = adc_link_pkg::H_IDLE;
            done = 1'b1;
            busy_nxt = 1'b0;
          end
        end
      end
      default: begin
        st_nxt = adc_link_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= adc_link_pkg::H_IDLE;
      tmr_r <= 6'h00;
      ph_r <= 3'h0;
      cnt_r <= 5'h00;
      cnv_r <= 1'b0;
      bclk_r <= 1'b0;
      self_r <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      ph_r <= ph_nxt;
      cnt_r <= cnt_nxt;
      cnv_r <= cnv_nxt;
      bclk_r <= bclk_nxt;
      self_r <= self_nxt;
      busy_out <= busy_nxt;
    end
  end

  // ************************************************
  // Echo-mode capture
  // ************************************************
  // Data and echo share one sync depth, so the echo rise lands mid-bit
  assign clr = (st_r == adc_link_pkg::H_IDLE) && start_in;
  always_comb begin
    esr_nxt = esr_r;
    if (clr) begin
      esr_nxt = 16'h0000;
    end else if (echo_rise) begin
      esr_nxt = {esr_r[14:0], sdata_s};
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      esr_r <= 16'h0000;
    end else begin
      esr_r <= esr_nxt;
    end
  end

  // ************************************************
  // Self-clocked three-phase capture
  // ************************************************
  // Each phase waits for the header one, then takes the zero and sixteen bits
  assign smp_en = (st_r == adc_link_pkg::H_BURST) || (st_r == adc_link_pkg::H_TAIL);
  for (genvar k = 0; k < 3; k++) begin : g_ph
    logic fnd_r, fnd_nxt;
    logic [4:0] pc_r, pc_nxt;
    logic [16:0] pd_r, pd_nxt;
    always_comb begin
      fnd_nxt = fnd_r;
      pc_nxt = pc_r;
      pd_nxt = pd_r;
      if (clr) begin
        fnd_nxt = 1'b0;
        pc_nxt = 5'h00;
        pd_nxt = 17'h00000;
      end else if (smp_en && (ph_r == 3'(k * `PHASE_STEP_CYC))) begin
        if (!fnd_r) begin
          fnd_nxt = sdata_s;
        end else if (pc_r != 5'(`ECHO_PULSES + 1)) begin
          pd_nxt = {pd_r[15:0], sdata_s};
          pc_nxt = pc_r + 5'h01;
        end
      end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        fnd_r <= 1'b0;
        pc_r <= 5'h00;
        pd_r <= 17'h00000;
      end else begin
        fnd_r <= fnd_nxt;
        pc_r <= pc_nxt;
        pd_r <= pd_nxt;
      end
    end
    assign ok[k] = fnd_r && (pc_r == 5'(`ECHO_PULSES + 1)) && !pd_r[16];
    assign word[k] = pd_r[15:0];
  end

  // ************************************************
  // Result hand-off
  // ************************************************
  // The middle phase is preferred since it sits farthest from either bit edge
  always_comb begin
    res_nxt = result_out;
    val_nxt = 1'b0;
    err_nxt = header_err_out;
    if (clr) begin
      err_nxt = 1'b0;
    end else if (done) begin
      val_nxt = 1'b1;
      err_nxt = 1'b0;
      if (!self_r) begin
        res_nxt = esr_r;
      end else if (ok[1]) begin
        res_nxt = word[1];
      end else if (ok[2]) begin
        res_nxt = word[2];
      end else if (ok[0]) begin
        res_nxt = word[0];
      end else begin
        val_nxt = 1'b0;
        err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_out <= 16'h0000;
      result_valid_out <= 1'b0;
      header_err_out <= 1'b0;
    end else begin
      result_out <= res_nxt;
      result_valid_out <= val_nxt;
      header_err_out <= err_nxt;
    end
  end

  assign link.conversion_start = cnv_r;
  assign link.burst_clk = bclk_r;
  assign link.ref_mode_sel_hi = ref_r[1];
  assign link.ref_mode_sel_lo = ref_r[0];
  assign link.self_clock_tie = self_r;
endmodule

// *** rtl/adc_link_defs.svh ***
`ifndef ADC_LINK_DEFS_SVH
`define ADC_LINK_DEFS_SVH
// Functional notes
// - Both select pins low powers down
// - Host waits mode wake-up before trusting results (code only reports settled_out; results are not gated)
// - Host may start converting right after selection
// - Conversion starts on start-pin rising edge
// - First result invalid; spacing within max period
// - Starts during conversion are ignored
// - Host ends start pulse within max width
// - Echo mode: echo clock, data on falls
// - Echo mode: host shifts on echo rises
// - Echo mode: 16 pulses inside read window
// - Echo mode: data and echo zero in blank
// - Tied echo pin selects self-clocked mode
// - Self mode: 010 header precedes each word
// - Self mode: exactly 18 pulses per window
// - Self mode: burst clock idles high
// - Self mode: bits leave on burst falls
// - Host picks one of three phases
// - Capture timing adapts per converter delay
// - Result is 16 bits, MSB first, twos complement

// Clock rate
`define CLK_NS 100
`define CLK_PER_US 10
// Converter timing
`define MSB_READY_NS 2000
`define MSB_READY_CYC ((`MSB_READY_NS + `CLK_NS - 1) / `CLK_NS)
`define LAST_CLOCK_NS 1000
`define LAST_CLOCK_CYC (`LAST_CLOCK_NS / `CLK_NS)
`define CONV_PERIOD_MAX_NS 50000
`define CONV_PERIOD_MAX_CYC (`CONV_PERIOD_MAX_NS / `CLK_NS)
`define START_HIGH_MAX_NS 500
`define START_HIGH_CYC (`START_HIGH_MAX_NS / `CLK_NS)
// Wake-up times per reference mode
`define WAKE_INT_US 9500000
`define WAKE_EXT12_US 25000
`define WAKE_EXTREF_US 65
`define WAKE_EXTREF_CYC (`WAKE_EXTREF_US * `CLK_PER_US)
// Word and burst layout, reference mode codes
`define ECHO_PULSES 16
`define SELF_PULSES 18
`define SELF_HEADER 3'h2
`define BURST_PERIOD_CYC 6
`define BURST_HALF_CYC 3
`define PHASE_STEP_CYC 2
`define HOST_MARGIN_CYC 2
`define TAIL_PERIODS 3
`define REF_POWER_DOWN 2'h0
`define REF_EXT12 2'h1
`define REF_EXTFULL 2'h2
`define REF_INTERNAL 2'h3
`endif

// *** rtl/adc_link_if.sv ***
`timescale 1ns/1ps
// Pins between converter and host; the board strap for the echo pin is self_clock_tie
interface adc_link_if;
  logic conversion_start;
  logic burst_clk;
  logic serial_data;
  logic echo_clock_out;
  logic ref_mode_sel_hi;
  logic ref_mode_sel_lo;
  logic self_clock_tie;
  modport device (
    input conversion_start,
    input burst_clk,
    input ref_mode_sel_hi,
    input ref_mode_sel_lo,
    input self_clock_tie,
    output serial_data,
    output echo_clock_out
  );
  modport host (
    output conversion_start,
    output burst_clk,
    output ref_mode_sel_hi,
    output ref_mode_sel_lo,
    output self_clock_tie,
    input serial_data,
    input echo_clock_out
  );
endinterface

// *** rtl/adc_link_pkg.sv ***
package adc_link_pkg;
  typedef enum logic [1:0] {
    D_PD = 2'h0,
    D_IDLE = 2'h1,
    D_CONV = 2'h2
  } dev_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_WAIT = 2'h1,
    H_BURST = 2'h2,
    H_TAIL = 2'h3
  } host_state_t;
endpackage

// *** rtl/edge_sync.sv ***
`timescale 1ns/1ps
module edge_sync (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;

  // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  always_comb begin
    sh_nxt = {sh_r[1:0], async_in};
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_r <= 3'h0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  assign level_out = sh_r[1];
  assign rise_out = sh_r[1] & ~sh_r[2];
  assign fall_out = ~sh_r[1] & sh_r[2];
endmodule
